// >>> core/srps_defs.svh
// Timing figures and reset values of the suspend and resume power sequencer
`ifndef SRPS_DEFS_SVH
`define SRPS_DEFS_SVH

`define SRPS_CLK_PERIOD_NS    100
`define SRPS_TICK_US          32
`define SRPS_TICK_CYCLES      ((`SRPS_TICK_US * 1000) / `SRPS_CLK_PERIOD_NS)
`define SRPS_PLL_LOCK_MS      16
`define SRPS_PLL_LOCK_TICKS   ((`SRPS_PLL_LOCK_MS * 1000 + `SRPS_TICK_US - 1) / `SRPS_TICK_US)
`define SRPS_STAT_DELAY_MS    1
`define SRPS_STAT_DELAY_TICKS ((`SRPS_STAT_DELAY_MS * 1000 + `SRPS_TICK_US - 1) / `SRPS_TICK_US)
`define SRPS_STEP_TICKS       1
`define SRPS_PG_TICKS         1
`define SRPS_HOLD_TICKS       2

`define SRPS_RST_PLANE_N      1'h1
`define SRPS_RST_REQ_N        1'h1
`define SRPS_RST_STATUS_N     2'h0
`define SRPS_RST_BUS_RESET_N  1'h0
`define SRPS_RST_PROC_RESET   1'h1
`define SRPS_RST_SCLK         1'h0
`define SRPS_RST_PIN_OE       1'h0
`define SRPS_RST_PIN_OUT      1'h1

`endif

// >>> core/srps_pkg.sv
// Types shared by the suspend and resume power sequencer
package srps_pkg;

    typedef enum logic [3:0] {
        SqOn, SqEnWait, SqEnHalt, SqEnSleep, SqEnStat, SqEnCstop, SqEnPlane, SqSusp,
        SqDown, SqRsWait, SqRsPower, SqRsClkRun, SqRsStat, SqRsBus
    } srps_state_t;

    typedef enum logic [1:0] {
        KindMemory, KindStorage, KindSoftOff
    } srps_kind_t;

    // Three-state clock-stop pin: level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } srps_pin_t;

endpackage : srps_pkg

// >>> core/srps_sequencer.sv
// Suspend and resume power sequencer
// Summary of operation
// - Steps timed in 32 us timebase ticks
// - Memory resume: planes AB after one tick
// - Storage resume: planes A-C after one tick
// - Power-on: resets on, requests off, float
// - Power good: clock-stop active, release after tick
// - Memory resume: clock-stop release 16 ms later
// - Storage resume: clock-stop release 16 ms later
// - Status release 1 ms after clock-stop release
// - Clock-stop frozen two ticks after status
// - Bus reset release one tick after status
// - Storage: suspend clock, bus reset one tick
// - Processor reset one tick after bus
// - Halt request one tick after clock-stop idle
// - Sleep one tick after halt, stop grant
// - Status within one tick of sleep
// - Clock-stop within tick, under clock control
// - Storage entry: planes A-C within tick
// - Storage entry: suspend clock low next
// - Power fail: float, resets, requests off
// - Suspended with power: outputs hold, suspend clock runs in memory suspend
`include "srps_defs.svh"

module srps_sequencer
    import srps_pkg::*;
#(
    parameter int TICK_CYCLES = `SRPS_TICK_CYCLES,
    parameter int PLL_TICKS   = `SRPS_PLL_LOCK_TICKS,
    parameter int STAT_TICKS  = `SRPS_STAT_DELAY_TICKS,
    parameter int WAIT_W      = 10
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       powerGood,
    input  wire logic       resumeEvent,
    input  wire logic       suspendReq,
    input  wire srps_kind_t suspendKind,
    input  wire logic       clockControl,
    input  wire logic       stopGrantDone,
    output srps_pin_t       busClockHaltN,
    output srps_pin_t       procClockHaltN,
    output logic            planeAbOffN,
    output logic            planeAcOffN,
    output logic            busResetAltN,
    output logic            procReset,
    output logic            procSleepN,
    output logic            procHaltReqN,
    output logic [1:0]      suspendStateN,
    output logic            suspendClock
);

    logic [15:0]       tickDiv_q;
    logic              rtcTick_q;
    logic              pgMeta_q;
    logic              pgSync_q;
    logic [1:0]        pgTicks_q;
    logic              suspPend_q;
    logic              resumePend_q;
    srps_kind_t        kindPend_q;
    logic              clkCtlPend_q;
    srps_kind_t        kind_q;
    logic              clkCtl_q;
    srps_state_t       state_q;
    srps_state_t       state_d;
    logic [WAIT_W-1:0] waitCnt_q;
    logic              takeSusp;
    logic              takeResume;
    logic              poweredUp;
    logic              floatCs;
    logic              activeCs;
    logic              sclkRun;
    srps_pin_t         pin_q;

    function automatic logic ticksDone(input int n);
        ticksDone = rtcTick_q && (waitCnt_q >= WAIT_W'(n - 1));
    endfunction : ticksDone

    // Timebase tick, one pulse per period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tickDiv_q <= 16'h0000;
            rtcTick_q <= 1'h0;
        end else if (tickDiv_q == 16'(TICK_CYCLES - 1)) begin
            tickDiv_q <= 16'h0000;
            rtcTick_q <= 1'h1;
        end else begin
            tickDiv_q <= tickDiv_q + 16'h0001;
            rtcTick_q <= 1'h0;
        end
    end

    // Power good pin synchroniser and tick count since it rose
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pgMeta_q  <= 1'h0;
            pgSync_q  <= 1'h0;
            pgTicks_q <= 2'h0;
        end else begin
            pgMeta_q <= powerGood;
            pgSync_q <= pgMeta_q;
            if (!pgSync_q) begin
                pgTicks_q <= 2'h0;
            end else if (rtcTick_q && pgTicks_q != 2'h3) begin
                pgTicks_q <= pgTicks_q + 2'h1;
            end
        end
    end

    assign takeSusp   = rtcTick_q && state_q == SqOn && suspPend_q;
    assign takeResume = rtcTick_q && state_q inside {SqOn, SqSusp, SqDown};

    // Pending requests; a new request wins over the clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspPend_q   <= 1'h0;
            resumePend_q <= 1'h0;
            kindPend_q   <= KindStorage;
            clkCtlPend_q <= 1'h0;
        end else begin
            if (suspendReq) begin
                suspPend_q   <= 1'h1;
                kindPend_q   <= suspendKind;
                clkCtlPend_q <= clockControl;
            end else if (takeSusp) begin
                suspPend_q <= 1'h0;
            end
            if (resumeEvent) begin
                resumePend_q <= 1'h1;
            end else if (takeResume) begin
                resumePend_q <= 1'h0;
            end
        end
    end

    // Suspend kind of the current cycle; cold start counts as storage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            kind_q   <= KindStorage;
            clkCtl_q <= 1'h0;
        end else if (takeSusp) begin
            kind_q   <= kindPend_q;
            clkCtl_q <= clkCtlPend_q;
        end
    end

    assign poweredUp = state_q inside {SqOn, SqEnWait, SqEnHalt, SqEnSleep, SqEnStat, SqEnCstop,
                                       SqEnPlane, SqSusp, SqRsClkRun, SqRsStat, SqRsBus};

    // Sequencing steps advance on ticks, except the jump to SqDown on power fail
    always_comb begin
        state_d = state_q;
        if (poweredUp && !pgSync_q) begin
            state_d = SqDown;
        end else begin
            case (state_q)
                SqOn: begin
                    if (takeSusp) state_d = SqEnWait;
                end
                SqEnWait: begin
                    if (ticksDone(`SRPS_STEP_TICKS)) state_d = SqEnHalt;
                end
                SqEnHalt: begin
                    if (ticksDone(`SRPS_STEP_TICKS) && stopGrantDone) state_d = SqEnSleep;
                end
                SqEnSleep: begin
                    if (rtcTick_q) state_d = SqEnStat;
                end
                SqEnStat: begin
                    if (rtcTick_q) state_d = SqEnCstop;
                end
                SqEnCstop: begin
                    if (rtcTick_q) state_d = SqEnPlane;
                end
                SqEnPlane: begin
                    if (rtcTick_q) state_d = SqSusp;
                end
                SqSusp, SqDown: begin
                    if (rtcTick_q && resumePend_q) state_d = SqRsWait;
                end
                SqRsWait: begin
                    if (ticksDone(`SRPS_STEP_TICKS)) state_d = SqRsPower;
                end
                SqRsPower: begin
                    if (ticksDone(PLL_TICKS) && pgTicks_q >= 2'(`SRPS_PG_TICKS)) begin
                        state_d = SqRsClkRun;
                    end
                end
                SqRsClkRun: begin
                    if (ticksDone(STAT_TICKS)) state_d = SqRsStat;
                end
                SqRsStat: begin
                    if (ticksDone(`SRPS_STEP_TICKS)) state_d = SqRsBus;
                end
                SqRsBus: begin
                    if (ticksDone(`SRPS_STEP_TICKS)) state_d = SqOn;
                end
                default: state_d = SqDown;
            endcase
        end
    end

    // State register and tick count within the state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= SqRsPower;
            waitCnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                waitCnt_q <= '0;
            end else if (rtcTick_q && waitCnt_q != '1) begin
                waitCnt_q <= waitCnt_q + WAIT_W'(1);
            end
        end
    end

    // Power-plane controls
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            planeAbOffN <= `SRPS_RST_PLANE_N;
            planeAcOffN <= `SRPS_RST_PLANE_N;
        end else begin
            planeAbOffN <= !(state_q inside {SqEnPlane, SqSusp, SqDown, SqRsWait});
            planeAcOffN <= !(state_q inside {SqEnPlane, SqSusp, SqDown, SqRsWait}
                             && kind_q != KindMemory);
        end
    end

    // Processor and bus resets
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busResetAltN <= `SRPS_RST_BUS_RESET_N;
            procReset    <= `SRPS_RST_PROC_RESET;
        end else begin
            busResetAltN <= poweredUp && !(state_q inside {SqRsClkRun, SqRsStat});
            procReset    <= !(poweredUp && !(state_q inside {SqRsClkRun, SqRsStat, SqRsBus}));
        end
    end

    // Processor halt and sleep requests
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            procHaltReqN <= `SRPS_RST_REQ_N;
            procSleepN   <= `SRPS_RST_REQ_N;
        end else begin
            procHaltReqN <= !(state_q inside {SqEnHalt, SqEnSleep, SqEnStat, SqEnCstop,
                                              SqEnPlane, SqSusp});
            procSleepN   <= !(state_q inside {SqEnSleep, SqEnStat, SqEnCstop,
                                              SqEnPlane, SqSusp});
        end
    end

    // Suspend status outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspendStateN <= `SRPS_RST_STATUS_N;
        end else begin
            suspendStateN <= {2{!(state_q inside {SqEnStat, SqEnCstop, SqEnPlane, SqSusp,
                SqDown, SqRsWait, SqRsPower, SqRsClkRun})}};
        end
    end

    // Suspend clock, stopped only in a storage or soft-off suspend and its resume up to SqRsStat
    assign sclkRun = kind_q == KindMemory
                     || !(state_q inside {SqSusp, SqDown, SqRsWait, SqRsPower, SqRsClkRun, SqRsStat});

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspendClock <= `SRPS_RST_SCLK;
        end else if (!sclkRun) begin
            suspendClock <= 1'h0;
        end else if (rtcTick_q) begin
            suspendClock <= !suspendClock;
        end
    end

    // Clock-stop pins: float without power, active until released
    assign floatCs  = !pgSync_q && state_q inside {SqDown, SqRsWait, SqRsPower};
    assign activeCs = state_q inside {SqRsWait, SqRsPower}
                      || (clkCtl_q && state_q inside {SqEnCstop, SqEnPlane, SqSusp});

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_q.oe  <= `SRPS_RST_PIN_OE;
            pin_q.out <= `SRPS_RST_PIN_OUT;
        end else begin
            pin_q.oe  <= !floatCs;
            pin_q.out <= !activeCs;
        end
    end

    assign busClockHaltN  = pin_q;
    assign procClockHaltN = pin_q;

    // Cycle counts of how long each watched level has held
    localparam int NLVL    = 7;
    localparam int StepWin = TICK_CYCLES + 1;
    logic [NLVL-1:0] lvl;
    logic [23:0]     lvlCyc_q [NLVL];

    assign lvl = {!pgSync_q, !procHaltReqN, pgSync_q, planeAbOffN,
                  pin_q.oe && pin_q.out, suspendStateN[0], busResetAltN};

    for (genvar i = 0; i < NLVL; i++) begin : g_lvl
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                lvlCyc_q[i] <= 24'h000000;
            end else if (!lvl[i]) begin
                lvlCyc_q[i] <= 24'h000000;
            end else if (lvlCyc_q[i] != 24'hFFFFFF) begin
                lvlCyc_q[i] <= lvlCyc_q[i] + 24'h000001;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_proc_reset_gap: assert property ($fell(procReset) |-> lvlCyc_q[0] >= 24'(TICK_CYCLES))
        else $error("processor reset released too soon after bus reset");
    a_bus_reset_gap: assert property ($rose(busResetAltN) |-> lvlCyc_q[1] >= 24'(TICK_CYCLES))
        else $error("bus reset released too soon after status");
    a_status_wait: assert property ($rose(suspendStateN[0])
        |-> lvlCyc_q[2] >= 24'(STAT_TICKS * TICK_CYCLES))
        else $error("status released too soon after clock-stop");
    a_stop_plane_wait: assert property ($rose(pin_q.oe && pin_q.out)
        |-> lvlCyc_q[3] >= 24'(PLL_TICKS * TICK_CYCLES))
        else $error("clock-stop released before lock wait");
    a_stop_pg_wait: assert property ($rose(pin_q.oe && pin_q.out)
        |-> lvlCyc_q[4] >= 24'(TICK_CYCLES))
        else $error("clock-stop released too soon after power good");
    a_halt_entry: assert property ($fell(procHaltReqN) |-> lvlCyc_q[2] >= 24'(TICK_CYCLES))
        else $error("halt request too soon after clock-stop idle");
    a_sleep_entry: assert property ($fell(procSleepN)
        |-> lvlCyc_q[5] >= 24'(TICK_CYCLES) && $past(stopGrantDone, 2))
        else $error("sleep request too early");
    a_status_entry: assert property ($fell(procSleepN) |-> ##[1:StepWin] !suspendStateN[0])
        else $error("status not asserted within a tick of sleep");
    a_power_fail: assert property (lvlCyc_q[6] >= 24'(TICK_CYCLES)
        |-> procReset && !busResetAltN && !pin_q.oe && procSleepN && procHaltReqN)
        else $error("outputs not safe after power good fell");
    a_stop_hold: assert property ($changed(pin_q)
        |-> !suspendStateN[0] || lvlCyc_q[1] >= 24'(`SRPS_HOLD_TICKS * TICK_CYCLES))
        else $error("clock-stop changed too soon after status release");

    c_mem_suspend: cover property (state_q == SqSusp && kind_q == KindMemory);
    c_disk_suspend: cover property (state_q == SqSusp && kind_q != KindMemory && !suspendClock);
    c_resume_done: cover property ($fell(procReset));
    c_power_fail: cover property (state_q == SqDown);

endmodule : srps_sequencer

// >>> test/srps_partner.sv
// Processor, clock synthesizer and power supply around the sequencer
module srps_partner
    import srps_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      keepPower,
    input  wire srps_pin_t busClockHaltN,
    input  wire logic      planeAbOffN,
    input  wire logic      procHaltReqN,
    output logic           powerGood,
    output logic           stopGrantDone,
    output logic           clocksRunning
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GRANT = 30;
    localparam int PGDLY = 20;
    int   grantCnt = 0;
    int   pgCnt    = 0;
    logic clkWant  = 1'h0;
    logic supplyOn;
    assign supplyOn = planeAbOffN === 1'h1 || keepPower === 1'h1;
    initial begin
        powerGood     = 1'h0;
        stopGrantDone = 1'h0;
        clocksRunning = 1'h0;
    end
    // Supply is good a while after the planes switch on, drops at once
    always @(posedge mclk) begin
        pgCnt     <= supplyOn ? (pgCnt < PGDLY ? pgCnt + 1 : pgCnt) : 0;
        powerGood <= supplyOn && pgCnt >= PGDLY - 1;
    end
    // Stop-grant cycle completes well after the halt request
    always @(posedge mclk) begin
        grantCnt      <= procHaltReqN === 1'h0 ? grantCnt + 1 : 0;
        stopGrantDone <= procHaltReqN === 1'h0 && grantCnt >= GRANT - 1;
    end
    // Controlled clocks follow the clock-stop pins two clocks later
    always @(posedge mclk) begin
        clkWant       <= !(busClockHaltN.oe === 1'h1 && busClockHaltN.out === 1'h0);
        clocksRunning <= clkWant;
    end
endmodule : srps_partner

// >>> test/tb_srps_sequencer.sv
// Self-checking bench for the suspend and resume power sequencer
module tb_srps_sequencer
    import srps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T   = 8;
    localparam int PLL = 4;
    localparam int STA = 2;
    localparam int HALT = 0, SLEEP = 1, STAT = 2, POUT = 3, POE = 4, PAB = 5, PAC = 6;
    localparam int BRST = 7, PRST = 8, SCLK = 9, PG = 10, GNT = 11;
    logic        mclk         = 1'h0;
    logic        reset_n      = 1'h0;
    logic        resumeEvent  = 1'h0;
    logic        suspendReq   = 1'h0;
    srps_kind_t  suspendKind  = KindMemory;
    logic        clockControl = 1'h0;
    logic        keepPower    = 1'h0;
    logic        powerGood;
    logic        stopGrantDone;
    logic        clocksRunning;
    srps_pin_t   busClockHaltN;
    srps_pin_t   procClockHaltN;
    logic        planeAbOffN;
    logic        planeAcOffN;
    logic        busResetAltN;
    logic        procReset;
    logic        procSleepN;
    logic        procHaltReqN;
    logic [1:0]  suspendStateN;
    logic        suspendClock;
    logic [3:0]  pins;
    logic [3:0]  pinsPrev;
    logic [11:0] outs;
    logic [11:0] outsPrev;
    int          cyc        = 0;
    int          tE         = 0;
    int          tPin       = 0;
    int          tOut       = 0;
    int          fail_count = 0;
    int          n_tests    = 0;

    assign pins = {busClockHaltN, procClockHaltN};
    assign outs = {pins, planeAbOffN, planeAcOffN, busResetAltN, procReset, procSleepN,
                   procHaltReqN, suspendStateN};

    always #50 mclk = ~mclk;

    // Cycle count and the last cycle at which pins or outputs moved
    always @(posedge mclk) begin
        cyc      <= cyc + 1;
        pinsPrev <= pins;
        outsPrev <= outs;
        if (pinsPrev !== pins) tPin <= cyc;
        if (outsPrev !== outs) tOut <= cyc;
    end

    srps_sequencer #(
        .TICK_CYCLES (T),
        .PLL_TICKS   (PLL),
        .STAT_TICKS  (STA)
    ) dut_u (
        .mclk           (mclk),
        .reset_n        (reset_n),
        .powerGood      (powerGood),
        .resumeEvent    (resumeEvent),
        .suspendReq     (suspendReq),
        .suspendKind    (suspendKind),
        .clockControl   (clockControl),
        .stopGrantDone  (stopGrantDone),
        .busClockHaltN  (busClockHaltN),
        .procClockHaltN (procClockHaltN),
        .planeAbOffN    (planeAbOffN),
        .planeAcOffN    (planeAcOffN),
        .busResetAltN   (busResetAltN),
        .procReset      (procReset),
        .procSleepN     (procSleepN),
        .procHaltReqN   (procHaltReqN),
        .suspendStateN  (suspendStateN),
        .suspendClock   (suspendClock)
    );

    srps_partner partner_u (
        .mclk          (mclk),
        .keepPower     (keepPower),
        .busClockHaltN (busClockHaltN),
        .planeAbOffN   (planeAbOffN),
        .procHaltReqN  (procHaltReqN),
        .powerGood     (powerGood),
        .stopGrantDone (stopGrantDone),
        .clocksRunning (clocksRunning)
    );

    function automatic logic sig(input int s);
        case (s)
            HALT:    return procHaltReqN;
            SLEEP:   return procSleepN;
            STAT:    return suspendStateN[0];
            POUT:    return busClockHaltN.out;
            POE:     return busClockHaltN.oe;
            PAB:     return planeAbOffN;
            PAC:     return planeAcOffN;
            BRST:    return busResetAltN;
            PRST:    return procReset;
            SCLK:    return suspendClock;
            PG:      return powerGood;
            default: return stopGrantDone;
        endcase
    endfunction : sig

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic await(input int s, input logic v, output int t);
        int i;
        #1;
        for (i = 0; i < 400 && sig(s) !== v; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 400) begin
            check(sig(s), v);
            close_out();
        end
        t = cyc;
    endtask : await

    task automatic pulse(input logic sus, input srps_kind_t k, input logic cc);
        @(posedge mclk);
        suspendReq   <= sus;
        resumeEvent  <= !sus;
        suspendKind  <= k;
        clockControl <= cc;
        #1;
        tE = cyc;
        @(posedge mclk);
        suspendReq  <= 1'h0;
        resumeEvent <= 1'h0;
        #1;
    endtask : pulse

    task automatic tail(input logic disk);
        int t0, t1, t2, t3, t4;
        await(POUT, 1'h1, t0);
        await(STAT, 1'h1, t1);
        check(t1 - t0 >= STA * T, 1'h1);
        await(BRST, 1'h1, t2);
        check(t2 - t1 >= T && t2 - t1 <= T + 2, 1'h1);
        if (disk) begin
            await(SCLK, 1'h1, t4);
            check(t4 - t1 >= T, 1'h1);
        end
        await(PRST, 1'h0, t3);
        check(t3 - t2 >= T, 1'h1);
        check(tPin < t1, 1'h1);
    endtask : tail

    task automatic enter(input srps_kind_t k, input logic cc);
        int   t0, t1, t2, t3, tG;
        logic ok = 1'h1;
        @(posedge mclk);
        keepPower <= 1'h1;
        pulse(1'h1, k, cc);
        await(HALT, 1'h0, t0);
        check(t0 - tPin >= T, 1'h1);
        await(GNT, 1'h1, tG);
        check(procSleepN, 1'h1);
        await(SLEEP, 1'h0, t1);
        check(t1 - t0 >= T, 1'h1);
        await(STAT, 1'h0, t2);
        check(t2 - t1 <= T + 2, 1'h1);
        await(PAB, 1'h0, t3);
        check(pins, cc ? 4'h5 : 4'hF);
        check(tPin - t2 <= T + 3, 1'h1);
        check(t3 - t2 <= 2 * T + 2, 1'h1);
        check(planeAcOffN, k == KindMemory);
        check(clocksRunning, !cc);
        if (k != KindMemory) begin
            repeat (T + 2) @(posedge mclk);
            for (int i = 0; i < 2 * T; i++) begin
                @(posedge mclk);
                #1;
                ok = ok && suspendClock === 1'h0;
            end
            check(ok, 1'h1);
        end
    endtask : enter

    task automatic resume(input logic disk);
        int tP, tR;
        pulse(1'h0, KindMemory, 1'h0);
        await(disk ? PAC : PAB, 1'h1, tP);
        check(tP - tE >= T, 1'h1);
        check(planeAbOffN, 1'h1);
        await(POE, 1'h1, tR);
        check(pins, 4'h5);
        await(POUT, 1'h1, tR);
        check(tR - tP >= PLL * T, 1'h1);
        tail(disk);
    endtask : resume

    task automatic power_fail;
        int t0;
        @(posedge mclk);
        keepPower <= 1'h0;
        await(PG, 1'h0, t0);
        repeat (T) @(posedge mclk);
        #1;
        check({busClockHaltN.oe, busResetAltN, procReset, procSleepN, procHaltReqN}, 5'h07);
    endtask : power_fail

    task automatic test_cold_boot;
        int tA, tB, tC;
        await(PG, 1'h1, tA);
        await(POE, 1'h1, tB);
        check(tB - tA <= 4, 1'h1);
        check(pins, 4'h5);
        await(POUT, 1'h1, tC);
        check(tC - tA >= T, 1'h1);
        tail(1'h0);
    endtask : test_cold_boot

    task automatic test_mem_suspend;
        int tS;
        enter(KindMemory, 1'h1);
        repeat (2) @(posedge mclk);
        #1;
        tS = tOut;
        repeat (4 * T) @(posedge mclk);
        #1;
        check(tOut == tS, 1'h1);
        resume(1'h0);
    endtask : test_mem_suspend

    task automatic test_disk_fail;
        enter(KindStorage, 1'h0);
        power_fail();
        resume(1'h1);
    endtask : test_disk_fail

    task automatic test_softoff_fail;
        enter(KindSoftOff, 1'h1);
        power_fail();
        resume(1'h1);
    endtask : test_softoff_fail

    initial begin
        repeat (2) @(posedge mclk);
        #1;
        check({busClockHaltN.oe, busResetAltN, procReset, procSleepN, procHaltReqN}, 5'h07);
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        test_cold_boot();
        test_mem_suspend();
        test_disk_fail();
        test_softoff_fail();
        close_out();
    end
endmodule : tb_srps_sequencer
